// ---- core/usbw_pkg.sv ----
// Package with constants and carrier types for the USB wake event block
package usbw_pkg;

  // ==========================================================================
  // Bus and register map
  // ==========================================================================
  localparam int USBW_ADDR_W = 18;
  localparam int USBW_DATA_W = 32;
  localparam logic [15:0] USBW_IDX_WAKE_FLAGS = 16'h7f2a;
  localparam logic [15:0] USBW_IDX_WAKE_MASK = 16'h7f2b;
  localparam logic [15:0] USBW_IDX_IRQ_STATUS = 16'h7f2c;
  localparam logic [15:0] USBW_IDX_IRQ_MASK = 16'h7f2d;
  localparam logic [1:0] USBW_RESP_OKAY = 2'h0;
  localparam logic [1:0] USBW_RESP_DECERR = 2'h3;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int USBW_BIT_BUS_RESET = 2;
  localparam int USBW_BIT_RESUME = 1;
  localparam int USBW_BIT_POWER_EVENT = 0;
  localparam logic [7:0] USBW_WAKE_FLAGS_RST = 8'h00;
  localparam logic [7:0] USBW_WAKE_MASK_RST = 8'h07;
  localparam logic [7:0] USBW_WAKE_MASK_WR = 8'h06;
  localparam logic [7:0] USBW_IRQ_STATUS_RST = 8'h00;
  localparam logic [7:0] USBW_IRQ_MASK_RST = 8'h00;
  // Line synchronisers start in full-speed J, so reset never looks like a bus reset
  localparam logic [2:0] USBW_LINE_SYNC_RST = 3'b100;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int USBW_CLK_PERIOD_NS = 100;
  localparam int USBW_SE0_MIN_NS = 2500;
  localparam int USBW_SE0_CYCLES =
    (USBW_SE0_MIN_NS + USBW_CLK_PERIOD_NS - 1) / USBW_CLK_PERIOD_NS;
  localparam int USBW_SE0_CNT_W = 8;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic dp;
    logic dm;
  } usbw_line_s;

  typedef struct packed {
    logic bus_reset;
    logic resume;
  } usbw_detect_s;

endpackage : usbw_pkg

// ---- core/usbw_line_detect.sv ----
// Line state watcher: synchronises the bus lines and detects reset and resume
`timescale 1ns/1ps
`default_nettype none

module usbw_line_detect
  import usbw_pkg::*;
#(
  parameter int SE0_CYCLES = USBW_SE0_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire usbw_line_s line,
  input wire logic low_speed,
  input wire logic global_suspend,
  output usbw_detect_s detect
);

  // ==========================================================================
  // Two-stage synchronisers
  // ==========================================================================
  logic [2:0] sync_a;
  logic [2:0] sync_b;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_a <= USBW_LINE_SYNC_RST;
      sync_b <= USBW_LINE_SYNC_RST;
    end else begin
      sync_a <= {line.dp, line.dm, low_speed};
      sync_b <= sync_a;
    end
  end

  logic dp_s;
  logic dm_s;
  logic ls_s;
  assign dp_s = sync_b[2];
  assign dm_s = sync_b[1];
  assign ls_s = sync_b[0];

  // ==========================================================================
  // Single-ended zero duration
  // ==========================================================================
  logic [USBW_SE0_CNT_W-1:0] se0_cnt;
  logic se0;
  assign se0 = !dp_s && !dm_s;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      se0_cnt <= '0;
    end else if (!se0) begin
      se0_cnt <= '0;
    end else if (se0_cnt != USBW_SE0_CNT_W'(SE0_CYCLES)) begin
      se0_cnt <= se0_cnt + 1'b1;
    end
  end

  // J state polarity depends on the attached speed
  logic line_is_j;
  assign line_is_j = ls_s ? (!dp_s && dm_s) : (dp_s && !dm_s);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      detect <= '0;
    end else begin
      detect.bus_reset <= (se0_cnt == USBW_SE0_CNT_W'(SE0_CYCLES));
      detect.resume <= global_suspend && !line_is_j;
    end
  end

endmodule : usbw_line_detect

`default_nettype wire

// ---- core/usbw_wake_top.sv ----
// Wake event block: flags, masks, interrupt and oscillator restart with AXI4-Lite
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - A bus reset flag sets when both data lines stay low for 32 to 64 full-speed or 4 to 8 low-speed bit times; the code needs 25 clocks (2500 ns) of SE0.
// - A resume flag sets when the bus leaves the J state during global suspend.
// - Each flag sets only on a rising edge of its detection input, never again while it stays high.
// - Reading the wake source register clears all its flags.
// - Each source has a mask bit in the same position, one blocks it, and only unmasked flags raise the external interrupt.
// - Enabled wake events are routed to the power event flag at bit 0 of interrupt status one.
// - With the microcontroller clock stopped, an unmasked wake event restarts the ring and crystal oscillators.
module usbw_wake_top
  import usbw_pkg::*;
#(
  parameter int SE0_CYCLES = USBW_SE0_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic bus_dp,
  input wire logic bus_dm,
  input wire logic low_speed,
  input wire logic global_suspend,
  input wire logic mcu_clk_stopped,
  output logic external_irq_one,
  output logic power_irq,
  output logic ring_osc_restart,
  output logic xtal_osc_restart,
  input wire logic [USBW_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [USBW_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [USBW_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [USBW_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================================
  // Line detection
  // ==========================================================================
  usbw_line_s line;
  usbw_detect_s detect;
  assign line.dp = bus_dp;
  assign line.dm = bus_dm;

  usbw_line_detect #(
    .SE0_CYCLES(SE0_CYCLES)
  ) u_detect (
    .clk_sys(clk_sys),
    .rst(rst),
    .line(line),
    .low_speed(low_speed),
    .global_suspend(global_suspend),
    .detect(detect)
  );

  // ==========================================================================
  // Rising edge of each detection input
  // ==========================================================================
  usbw_detect_s detect_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      detect_q <= '0;
    end else begin
      detect_q <= detect;
    end
  end

  logic [7:0] wake_set;
  always_comb begin
    wake_set = 8'h00;
    wake_set[USBW_BIT_BUS_RESET] = detect.bus_reset && !detect_q.bus_reset;
    wake_set[USBW_BIT_RESUME] = detect.resume && !detect_q.resume;
  end

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [7:0] wake_source_flags;
  logic [7:0] wake_source_mask;
  logic [7:0] interrupt_status_one;
  logic [7:0] interrupt_mask_one;

  // ==========================================================================
  // Write channel
  // ==========================================================================
  logic aw_held;
  logic [USBW_ADDR_W-1:0] aw_addr;
  logic w_held;
  logic [USBW_DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  logic [USBW_ADDR_W-3:0] wr_idx;
  logic wr_hit_flags;
  logic wr_hit_mask;
  logic wr_hit_status;
  logic wr_hit_imask;
  logic wr_lane0;

  assign wr_idx = aw_addr[USBW_ADDR_W-1:2];
  assign wr_hit_flags = wr_idx == (USBW_ADDR_W-2)'(USBW_IDX_WAKE_FLAGS);
  assign wr_hit_mask = wr_idx == (USBW_ADDR_W-2)'(USBW_IDX_WAKE_MASK);
  assign wr_hit_status = wr_idx == (USBW_ADDR_W-2)'(USBW_IDX_IRQ_STATUS);
  assign wr_hit_imask = wr_idx == (USBW_ADDR_W-2)'(USBW_IDX_IRQ_MASK);
  assign wr_lane0 = do_write && w_strb[0];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= USBW_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (wr_hit_flags || wr_hit_mask || wr_hit_status || wr_hit_imask) begin
        s_axi_bresp <= USBW_RESP_OKAY;
      end else begin
        s_axi_bresp <= USBW_RESP_DECERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Read channel
  // ==========================================================================
  logic rd_take;
  logic [USBW_ADDR_W-3:0] rd_idx;
  logic rd_hit_flags;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[USBW_ADDR_W-1:2];
  assign rd_hit_flags = rd_idx == (USBW_ADDR_W-2)'(USBW_IDX_WAKE_FLAGS);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= USBW_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= USBW_RESP_OKAY;
      if (rd_hit_flags) begin
        s_axi_rdata <= {24'h00_0000, wake_source_flags};
      end else if (rd_idx == (USBW_ADDR_W-2)'(USBW_IDX_WAKE_MASK)) begin
        s_axi_rdata <= {24'h00_0000, wake_source_mask};
      end else if (rd_idx == (USBW_ADDR_W-2)'(USBW_IDX_IRQ_STATUS)) begin
        s_axi_rdata <= {24'h00_0000, interrupt_status_one};
      end else if (rd_idx == (USBW_ADDR_W-2)'(USBW_IDX_IRQ_MASK)) begin
        s_axi_rdata <= {24'h00_0000, interrupt_mask_one};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= USBW_RESP_DECERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Wake source flags and mask
  // ==========================================================================
  // An event in the read cycle survives into the next read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_source_flags <= USBW_WAKE_FLAGS_RST;
    end else if (rd_take && rd_hit_flags) begin
      wake_source_flags <= wake_set;
    end else begin
      wake_source_flags <= wake_source_flags | wake_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_source_mask <= USBW_WAKE_MASK_RST;
    end else if (wr_lane0 && wr_hit_mask) begin
      wake_source_mask <= (wake_source_mask & ~USBW_WAKE_MASK_WR)
        | (w_data[7:0] & USBW_WAKE_MASK_WR);
    end
  end

  logic [7:0] wake_unmasked;
  logic [7:0] wake_event_unmasked;
  assign wake_unmasked = wake_source_flags & ~wake_source_mask;
  assign wake_event_unmasked = wake_set & ~wake_source_mask;

  // ==========================================================================
  // Power event status and interrupts
  // ==========================================================================
  logic power_set;
  assign power_set = |wake_event_unmasked;

  // Hardware set wins over a simultaneous write-one clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      interrupt_status_one <= USBW_IRQ_STATUS_RST;
    end else begin
      if (wr_lane0 && wr_hit_status) begin
        interrupt_status_one[USBW_BIT_POWER_EVENT] <=
          (interrupt_status_one[USBW_BIT_POWER_EVENT]
          && !w_data[USBW_BIT_POWER_EVENT]) || power_set;
      end else begin
        interrupt_status_one[USBW_BIT_POWER_EVENT] <=
          interrupt_status_one[USBW_BIT_POWER_EVENT] || power_set;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      interrupt_mask_one <= USBW_IRQ_MASK_RST;
    end else if (wr_lane0 && wr_hit_imask) begin
      interrupt_mask_one[USBW_BIT_POWER_EVENT] <= w_data[USBW_BIT_POWER_EVENT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      external_irq_one <= 1'b0;
      power_irq <= 1'b0;
    end else begin
      external_irq_one <= |(wake_unmasked | wake_event_unmasked);
      power_irq <= (interrupt_status_one[USBW_BIT_POWER_EVENT] || power_set)
        && !interrupt_mask_one[USBW_BIT_POWER_EVENT];
    end
  end

  // ==========================================================================
  // Oscillator restart
  // ==========================================================================
  logic restart;
  assign restart = mcu_clk_stopped && (|(wake_unmasked | wake_event_unmasked));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ring_osc_restart <= 1'b0;
      xtal_osc_restart <= 1'b0;
    end else begin
      ring_osc_restart <= restart;
      xtal_osc_restart <= restart;
    end
  end

endmodule : usbw_wake_top

`default_nettype wire

// ---- verification/usbw_wake_assertions.sv ----
// Port checker for the wake event block
`timescale 1ns/1ps
`default_nettype none
module usbw_wake_assertions
  import usbw_pkg::*;
#(
  parameter int SE0_CYCLES = USBW_SE0_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic bus_dp,
  input wire logic bus_dm,
  input wire logic low_speed,
  input wire logic global_suspend,
  input wire logic mcu_clk_stopped,
  input wire logic external_irq_one,
  input wire logic power_irq,
  input wire logic ring_osc_restart,
  input wire logic xtal_osc_restart,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [USBW_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic rd_flags;
  logic cause;
  logic [3:0] age;
  assign rd_flags = s_axi_arvalid && s_axi_arready && s_axi_araddr[17:2] == USBW_IDX_WAKE_FLAGS;
  assign cause = (!bus_dp && !bus_dm) ||
    (global_suspend && {bus_dp, bus_dm} != {!low_speed, low_speed});
  // Cycles since the lines last showed something that can raise a flag
  always_ff @(posedge clk_sys) begin
    if (rst || cause) age <= 4'h0;
    else if (age != 4'hf) age <= age + 4'h1;
  end
  sequence quiet_read; rd_flags && age > 4'ha; endsequence
  sequence irq_gone; ##2 !external_irq_one; endsequence
  read_answer_a: assert property (rd_flags |=> s_axi_rvalid)
    else $error("flag read not answered");
  irq_drop_a: assert property (quiet_read |-> irq_gone)
    else $error("irq high after flag read");
  irq_hold_a: assert property (external_irq_one && s_axi_awready && !rd_flags &&
    !$past(rd_flags) |=> external_irq_one) else $error("irq dropped early");
  irq_cause_a: assert property ($rose(external_irq_one) |->
    age < SE0_CYCLES + 8 || $past(s_axi_bvalid)) else $error("irq without line event");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
  osc_start_a: assert property (external_irq_one && $past(mcu_clk_stopped) |->
    ring_osc_restart) else $error("oscillator not restarted");
  osc_cause_a: assert property (ring_osc_restart |-> external_irq_one &&
    $past(mcu_clk_stopped)) else $error("oscillator restart without cause");
  osc_pair_a: assert property (xtal_osc_restart == ring_osc_restart)
    else $error("oscillator restarts differ");
  power_fall_a: assert property ($fell(power_irq) |-> $past(s_axi_bvalid))
    else $error("power irq fell without write");
endmodule : usbw_wake_assertions
`default_nettype wire

// ---- verification/usbw_host_model.sv ----
// Host side line driver for the wake event block
`timescale 1ns/1ps
`default_nettype none
module usbw_host_model
  import usbw_pkg::*;
(
  input wire logic [1:0] mode,
  input wire logic low_speed,
  output usbw_line_s line
);
  // Mode 0 idles in J, 1 drives single-ended zero, 2 drives K
  always_comb begin
    case (mode)
      2'h1: line = 2'h0;
      2'h2: line = {low_speed, !low_speed};
      default: line = {!low_speed, low_speed};
    endcase
  end
endmodule : usbw_host_model
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking testbench for the wake event block
`timescale 1ns/1ps
`default_nettype none
module tb import usbw_pkg::*;;
  localparam int SE0_CYCLES = 3;
  logic clk_sys = 1'b0, rst = 1'b1, ls = 1'b0, susp = 1'b0, stop = 1'b0;
  logic [1:0] mode = 2'h0;
  usbw_line_s line;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awv = 1'b0, awr, wv = 1'b0, wrd, bv, br = 1'b0, arv = 1'b0, arr, rv, rr = 1'b0;
  logic [1:0] bresp, rresp;
  logic irq, pirq, rosc, xosc;
  int n_errors = 0, checks_done = 0;
  always #50 clk_sys = ~clk_sys;
  usbw_host_model usbw_host_model_i (.mode(mode), .low_speed(ls), .line(line));
  usbw_wake_top #(.SE0_CYCLES(SE0_CYCLES)) usbw_wake_top_i (
    .clk_sys(clk_sys), .rst(rst), .bus_dp(line.dp), .bus_dm(line.dm), .low_speed(ls),
    .global_suspend(susp), .mcu_clk_stopped(stop), .external_irq_one(irq), .power_irq(pirq),
    .ring_osc_restart(rosc), .xtal_osc_restart(xosc), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr));
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic tmo(input int i);
    if (i >= 40) begin
      n_errors++;
      $display("[ERR] %0t no bus answer", $time);
      final_report();
    end
  endtask : tmo
  task automatic wr(input logic [15:0] ix, input logic [7:0] d, input logic [1:0] er);
    int i;
    @(posedge clk_sys);
    awaddr <= {ix, 2'h0};
    wdata <= {24'h00_0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    tmo(i);
    br <= 1'b0;
    chk(bresp, er);
  endtask : wr
  task automatic rd(input logic [15:0] ix, input logic [7:0] e, input logic [1:0] er);
    int i;
    @(posedge clk_sys);
    araddr <= {ix, 2'h0};
    arv <= 1'b1;
    rr <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    tmo(i);
    rr <= 1'b0;
    chk({rresp, rdata}, {er, 24'h00_0000, e});
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic drive(input logic [1:0] m, input int n);
    @(posedge clk_sys);
    mode <= m;
    cyc(n);
    mode <= 2'h0;
  endtask : drive
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd(USBW_IDX_WAKE_FLAGS, 8'h00, USBW_RESP_OKAY);
    rd(USBW_IDX_WAKE_MASK, 8'h07, USBW_RESP_OKAY);
    rd(USBW_IDX_IRQ_STATUS, 8'h00, USBW_RESP_OKAY);
    rd(16'h0100, 8'h00, USBW_RESP_DECERR);
    wr(16'h0100, 8'hff, USBW_RESP_DECERR);
    wr(USBW_IDX_WAKE_MASK, 8'hff, USBW_RESP_OKAY);
    rd(USBW_IDX_WAKE_MASK, 8'h07, USBW_RESP_OKAY);
    $display("test 1 done");
    drive(2'h1, SE0_CYCLES - 1);
    cyc(8);
    rd(USBW_IDX_WAKE_FLAGS, 8'h00, USBW_RESP_OKAY);
    @(posedge clk_sys);
    mode <= 2'h1;
    cyc(SE0_CYCLES + 6);
    rd(USBW_IDX_WAKE_FLAGS, 8'h04, USBW_RESP_OKAY);
    cyc(10);
    rd(USBW_IDX_WAKE_FLAGS, 8'h00, USBW_RESP_OKAY);
    mode <= 2'h0;
    chk(irq, 1'b0);
    $display("test 2 done");
    wr(USBW_IDX_WAKE_MASK, 8'h00, USBW_RESP_OKAY);
    rd(USBW_IDX_WAKE_MASK, 8'h01, USBW_RESP_OKAY);
    @(posedge clk_sys);
    ls <= 1'b1;
    susp <= 1'b1;
    stop <= 1'b1;
    cyc(6);
    chk(irq, 1'b0);
    drive(2'h2, 3);
    cyc(10);
    chk({irq, rosc, xosc, pirq}, 4'hf);
    rd(USBW_IDX_WAKE_FLAGS, 8'h02, USBW_RESP_OKAY);
    cyc(2);
    chk({irq, rosc, xosc, pirq}, 4'h1);
    rd(USBW_IDX_IRQ_STATUS, 8'h01, USBW_RESP_OKAY);
    wr(USBW_IDX_IRQ_STATUS, 8'h01, USBW_RESP_OKAY);
    rd(USBW_IDX_IRQ_STATUS, 8'h00, USBW_RESP_OKAY);
    chk(pirq, 1'b0);
    susp <= 1'b0;
    stop <= 1'b0;
    ls <= 1'b0;
    $display("test 3 done");
    wr(USBW_IDX_IRQ_MASK, 8'h01, USBW_RESP_OKAY);
    drive(2'h1, SE0_CYCLES + 2);
    cyc(8);
    chk({irq, rosc, xosc, pirq}, 4'h8);
    rd(USBW_IDX_IRQ_STATUS, 8'h01, USBW_RESP_OKAY);
    rd(USBW_IDX_WAKE_FLAGS, 8'h04, USBW_RESP_OKAY);
    wr(USBW_IDX_IRQ_STATUS, 8'h01, USBW_RESP_OKAY);
    wr(USBW_IDX_WAKE_MASK, 8'h04, USBW_RESP_OKAY);
    drive(2'h1, SE0_CYCLES + 2);
    cyc(8);
    chk(irq, 1'b0);
    rd(USBW_IDX_WAKE_FLAGS, 8'h04, USBW_RESP_OKAY);
    $display("test 4 done");
    final_report();
  end
endmodule : tb
bind usbw_wake_top usbw_wake_assertions #(.SE0_CYCLES(SE0_CYCLES)) usbw_wake_assertions_i (
  .clk_sys(clk_sys), .rst(rst), .bus_dp(bus_dp), .bus_dm(bus_dm), .low_speed(low_speed),
  .global_suspend(global_suspend), .mcu_clk_stopped(mcu_clk_stopped),
  .external_irq_one(external_irq_one), .power_irq(power_irq),
  .ring_osc_restart(ring_osc_restart), .xtal_osc_restart(xtal_osc_restart),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire
